// file: shared/oart_pkg.sv
// Package for the optical front-end result and timing register slice.
// Assumes an APB master with 32-bit data; printed offsets are register indices.
package oart_pkg;
    localparam int           ADDR_W           = 12;
    localparam logic [7:0]   IDX_LED1         = 8'h2C;
    localparam logic [7:0]   IDX_AMB1         = 8'h2D;
    localparam logic [7:0]   IDX_DIFF2        = 8'h2E;
    localparam logic [7:0]   IDX_DIFF1        = 8'h2F;
    localparam logic [7:0]   IDX_CFG          = 8'h31;
    localparam logic [7:0]   IDX_PDN_BEGIN    = 8'h32;
    localparam logic [7:0]   IDX_PDN_FINISH   = 8'h33;
    localparam logic [7:0]   IDX_PULSE_BEGIN  = 8'h34;
    localparam logic [7:0]   IDX_CTRL         = 8'h40;
    localparam int           CFG_SHORT_BIT    = 5;
    localparam int           CFG_DIV_LSB      = 0;
    localparam int           CTRL_OSC_BIT     = 0;
    localparam int           CTRL_AMPDYN_BIT  = 1;
    localparam logic [23:0]  RESULT_RST       = 24'h00_0000;
    localparam logic [15:0]  COUNT_RST        = 16'h0000;
    localparam logic [2:0]   DIV_RST          = 3'h0;
    localparam logic [2:0]   DIV_CODE_2       = 3'h0;
    localparam logic [2:0]   DIV_CODE_8       = 3'h1;
    localparam logic [2:0]   DIV_CODE_12      = 3'h3;
    localparam logic [2:0]   DIV_CODE_4       = 3'h4;
    localparam logic [2:0]   DIV_CODE_1       = 3'h5;
    localparam logic [2:0]   DIV_CODE_6       = 3'h6;
    localparam logic [3:0]   DIV_RATIO_2      = 4'h2;
    localparam logic [3:0]   DIV_RATIO_8      = 4'h8;
    localparam logic [3:0]   DIV_RATIO_12     = 4'hC;
    localparam logic [3:0]   DIV_RATIO_4      = 4'h4;
    localparam logic [3:0]   DIV_RATIO_1      = 4'h1;
    localparam logic [3:0]   DIV_RATIO_6      = 4'h6;

    typedef struct packed {
        logic        shortEn;
        logic [2:0]  externalClockDivider;
        logic        internalOscillatorSelect;
        logic        ampDynamicPowerdownSelect;
        logic [15:0] powerdownWindowBegin;
        logic [15:0] powerdownWindowFinish;
        logic [15:0] spareTimingPulseBegin;
    } oart_cfg_t;
endpackage

// file: hw/oart_regs.sv
// Result and timing register slice of an optical heart-rate front end.
// Assumes an APB master on clk, and sample results and engine count from the core.
`timescale 1ns/1ps

module oart_regs (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [oart_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      sampleValid,
    input  wire logic [23:0]               firstLedSample,
    input  wire logic [23:0]               firstAmbientSample,
    input  wire logic [23:0]               secondLedSample,
    input  wire logic [23:0]               secondAmbientSample,
    input  wire logic [15:0]               engineCount,
    input  wire logic                      externalClockIn,
    output logic                           dividedClock,
    output logic                           ampPowerdown,
    output logic                           inputsToCommonMode,
    output logic                           clockPinIsInput,
    output logic [15:0]                    spareTimingPulseBegin
);
    logic                  rstMeta_r;
    logic                  rstSync_r;
    logic [23:0]           led1_r, led1_nxt;
    logic [23:0]           amb1_r, amb1_nxt;
    logic [23:0]           diff2_r, diff2_nxt;
    logic [23:0]           diff1_r, diff1_nxt;
    oart_pkg::oart_cfg_t   cfg_r, cfg_nxt;
    logic [31:0]           prdata_nxt;
    logic                  pready_nxt;
    logic                  pslverr_nxt;
    logic [3:0]            divCnt_r, divCnt_nxt;
    logic                  divClk_r, divClk_nxt;
    logic                  extPrev_r;
    logic                  ampPdn_nxt;
    logic                  short_nxt;
    logic [3:0]            ratio;
    logic                  window;
    logic [7:0]            idx;
    logic                  access;
    logic                  mapped;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_r <= 1'b0;
            rstSync_r <= 1'b0;
        end else begin
            rstMeta_r <= 1'b1;
            rstSync_r <= rstMeta_r;
        end
    end

    // Word index from byte address
    assign idx    = paddr[9:2];
    assign access = psel && penable && !pready;

    always_comb begin
        unique case (idx)
            oart_pkg::IDX_LED1, oart_pkg::IDX_AMB1, oart_pkg::IDX_DIFF2,
            oart_pkg::IDX_DIFF1, oart_pkg::IDX_CFG, oart_pkg::IDX_PDN_BEGIN,
            oart_pkg::IDX_PDN_FINISH, oart_pkg::IDX_PULSE_BEGIN,
            oart_pkg::IDX_CTRL: mapped = (paddr[1:0] == 2'b00)
                                      && (paddr[oart_pkg::ADDR_W-1:10] == '0);
            default:            mapped = 1'b0;
        endcase
    end

    // Result capture
    always_comb begin
        led1_nxt  = led1_r;
        amb1_nxt  = amb1_r;
        diff2_nxt = diff2_r;
        diff1_nxt = diff1_r;
        if (sampleValid) begin
            led1_nxt  = firstLedSample;
            amb1_nxt  = firstAmbientSample;
            diff2_nxt = secondLedSample - secondAmbientSample;
            diff1_nxt = firstLedSample - firstAmbientSample;
        end
    end

    // APB writes and reads
    always_comb begin
        cfg_nxt     = cfg_r;
        prdata_nxt  = prdata;
        pready_nxt  = access;
        pslverr_nxt = 1'b0;
        if (access) begin
            pslverr_nxt = !mapped;
            prdata_nxt  = 32'h0000_0000;
            if (pwrite && mapped) begin
                unique case (idx)
                    oart_pkg::IDX_CFG: begin
                        cfg_nxt.shortEn              = pwdata[oart_pkg::CFG_SHORT_BIT];
                        cfg_nxt.externalClockDivider =
                            pwdata[oart_pkg::CFG_DIV_LSB +: 3];
                    end
                    oart_pkg::IDX_PDN_BEGIN:   cfg_nxt.powerdownWindowBegin  = pwdata[15:0];
                    oart_pkg::IDX_PDN_FINISH:  cfg_nxt.powerdownWindowFinish = pwdata[15:0];
                    oart_pkg::IDX_PULSE_BEGIN: cfg_nxt.spareTimingPulseBegin = pwdata[15:0];
                    oart_pkg::IDX_CTRL: begin
                        cfg_nxt.internalOscillatorSelect  = pwdata[oart_pkg::CTRL_OSC_BIT];
                        cfg_nxt.ampDynamicPowerdownSelect = pwdata[oart_pkg::CTRL_AMPDYN_BIT];
                    end
                    default: ;
                endcase
            end else if (!pwrite && mapped) begin
                unique case (idx)
                    oart_pkg::IDX_LED1:  prdata_nxt = {8'h00, led1_r};
                    oart_pkg::IDX_AMB1:  prdata_nxt = {8'h00, amb1_r};
                    oart_pkg::IDX_DIFF2: prdata_nxt = {8'h00, diff2_r};
                    oart_pkg::IDX_DIFF1: prdata_nxt = {8'h00, diff1_r};
                    oart_pkg::IDX_CFG:
                        prdata_nxt = {26'h00_0000, cfg_r.shortEn, 2'b00,
                                      cfg_r.externalClockDivider};
                    oart_pkg::IDX_PDN_BEGIN:
                        prdata_nxt = {16'h0000, cfg_r.powerdownWindowBegin};
                    oart_pkg::IDX_PDN_FINISH:
                        prdata_nxt = {16'h0000, cfg_r.powerdownWindowFinish};
                    oart_pkg::IDX_CTRL:
                        prdata_nxt = {30'h000_0000, cfg_r.ampDynamicPowerdownSelect,
                                      cfg_r.internalOscillatorSelect};
                    default: prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // Divide ratio lookup
    always_comb begin
        unique case (cfg_r.externalClockDivider)
            oart_pkg::DIV_CODE_2:  ratio = oart_pkg::DIV_RATIO_2;
            oart_pkg::DIV_CODE_8:  ratio = oart_pkg::DIV_RATIO_8;
            oart_pkg::DIV_CODE_12: ratio = oart_pkg::DIV_RATIO_12;
            oart_pkg::DIV_CODE_4:  ratio = oart_pkg::DIV_RATIO_4;
            oart_pkg::DIV_CODE_1:  ratio = oart_pkg::DIV_RATIO_1;
            oart_pkg::DIV_CODE_6:  ratio = oart_pkg::DIV_RATIO_6;
            default:               ratio = oart_pkg::DIV_RATIO_2;
        endcase
    end

    // External clock divider, counts rising edges of the sampled pin
    always_comb begin
        divCnt_nxt = divCnt_r;
        divClk_nxt = divClk_r;
        if (cfg_r.internalOscillatorSelect) begin
            divCnt_nxt = 4'd0;
            divClk_nxt = 1'b0;
        end else if (externalClockIn && !extPrev_r) begin
            if (ratio == oart_pkg::DIV_RATIO_1) begin
                divClk_nxt = 1'b1;
                divCnt_nxt = 4'd0;
            end else if (divCnt_r >= ratio - 4'd1) begin
                divCnt_nxt = 4'd0;
                divClk_nxt = 1'b1;
            end else begin
                divCnt_nxt = divCnt_r + 4'd1;
                divClk_nxt = (divCnt_r + 4'd1) < (ratio >> 1);
            end
        end else if (ratio == oart_pkg::DIV_RATIO_1 && !externalClockIn && extPrev_r) begin
            divClk_nxt = 1'b0;
        end
    end

    // Powerdown window and input short
    assign window = (engineCount >= cfg_r.powerdownWindowBegin)
                 && (engineCount <  cfg_r.powerdownWindowFinish);
    assign ampPdn_nxt = cfg_r.ampDynamicPowerdownSelect && window;
    assign short_nxt  = cfg_r.shortEn && ampPdn_nxt;

    always_ff @(posedge clk or negedge rstSync_r) begin
        if (!rstSync_r) begin
            led1_r                <= oart_pkg::RESULT_RST;
            amb1_r                <= oart_pkg::RESULT_RST;
            diff2_r               <= oart_pkg::RESULT_RST;
            diff1_r               <= oart_pkg::RESULT_RST;
            cfg_r                 <= '0;
            prdata                <= 32'h0000_0000;
            pready                <= 1'b0;
            pslverr               <= 1'b0;
            divCnt_r              <= 4'd0;
            divClk_r              <= 1'b0;
            extPrev_r             <= 1'b0;
            dividedClock          <= 1'b0;
            ampPowerdown          <= 1'b0;
            inputsToCommonMode    <= 1'b0;
            clockPinIsInput       <= 1'b1;
            spareTimingPulseBegin <= oart_pkg::COUNT_RST;
        end else begin
            led1_r                <= led1_nxt;
            amb1_r                <= amb1_nxt;
            diff2_r               <= diff2_nxt;
            diff1_r               <= diff1_nxt;
            cfg_r                 <= cfg_nxt;
            prdata                <= prdata_nxt;
            pready                <= pready_nxt;
            pslverr               <= pslverr_nxt;
            divCnt_r              <= divCnt_nxt;
            divClk_r              <= divClk_nxt;
            extPrev_r             <= externalClockIn;
            dividedClock          <= divClk_nxt;
            ampPowerdown          <= ampPdn_nxt;
            inputsToCommonMode    <= short_nxt;
            clockPinIsInput       <= !cfg_nxt.internalOscillatorSelect;
            spareTimingPulseBegin <= cfg_nxt.spareTimingPulseBegin;
        end
    end

    // Checks
    led1_capture_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        sampleValid |=> led1_r == $past(firstLedSample))
        else $error("LED1 result not captured");
    amb1_capture_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        sampleValid |=> amb1_r == $past(firstAmbientSample))
        else $error("Ambient result not captured");
    diff2_value_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        sampleValid |=> diff2_r == $past(secondLedSample) - $past(secondAmbientSample))
        else $error("Second difference wrong");
    diff1_value_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        sampleValid |=> diff1_r == $past(firstLedSample) - $past(firstAmbientSample))
        else $error("First difference wrong");
    short_follows_pdn_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        inputsToCommonMode |-> ampPowerdown)
        else $error("Inputs shorted while amp powered");
    pdn_window_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (cfg_r.ampDynamicPowerdownSelect && window) |=> ampPowerdown)
        else $error("Amp not powered down in window");
    result_ro_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (!sampleValid && access && pwrite && idx == oart_pkg::IDX_LED1) |=> $stable(led1_r))
        else $error("Result register changed by write");
    ext_clock_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        clockPinIsInput == !cfg_r.internalOscillatorSelect)
        else $error("Clock pin direction wrong for clock mode");
    apb_ready_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (psel && penable && !pready) |=> pready ##1 !pready)
        else $error("APB answer not one cycle");
    amb1_ro_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (!sampleValid && access && pwrite && idx == oart_pkg::IDX_AMB1) |=> $stable(amb1_r))
        else $error("Ambient result changed by write");
    diff_ro_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (!sampleValid && access && pwrite
            && (idx == oart_pkg::IDX_DIFF1 || idx == oart_pkg::IDX_DIFF2))
        |=> ($stable(diff1_r) && $stable(diff2_r)))
        else $error("Difference result changed by write");
    pdn_outside_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (engineCount < cfg_r.powerdownWindowBegin
            || engineCount >= cfg_r.powerdownWindowFinish) |=> !ampPowerdown)
        else $error("Amp powered down outside window");
    short_in_window_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (cfg_r.shortEn && cfg_r.ampDynamicPowerdownSelect && window) |=> inputsToCommonMode)
        else $error("Inputs not shorted while amp down");
    short_off_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        !cfg_r.shortEn |=> !inputsToCommonMode)
        else $error("Inputs shorted with short disabled");
    div_one_rise_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (!cfg_r.internalOscillatorSelect && cfg_r.externalClockDivider == oart_pkg::DIV_CODE_1
            && externalClockIn && !extPrev_r) |=> dividedClock)
        else $error("Divide by one missed a rising edge");
    div_one_fall_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (!cfg_r.internalOscillatorSelect && cfg_r.externalClockDivider == oart_pkg::DIV_CODE_1
            && !externalClockIn && extPrev_r) |=> !dividedClock)
        else $error("Divide by one missed a falling edge");
    osc_div_idle_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        cfg_r.internalOscillatorSelect |=> !dividedClock)
        else $error("Divider running in oscillator mode");
    bad_addr_err_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (access && !mapped) |=> (pready && pslverr))
        else $error("Unmapped access without error");
    good_addr_ok_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (access && mapped) |=> (pready && !pslverr))
        else $error("Mapped access answered with error");
    apb_idle_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        !psel |=> !pready)
        else $error("Ready raised while not selected");
    cfg_write_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (access && pwrite && mapped && idx == oart_pkg::IDX_CFG)
        |=> (cfg_r.externalClockDivider == $past(pwdata[oart_pkg::CFG_DIV_LSB +: 3])
            && cfg_r.shortEn == $past(pwdata[oart_pkg::CFG_SHORT_BIT])))
        else $error("Configuration write not stored");
    pdn_begin_write_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (access && pwrite && mapped && idx == oart_pkg::IDX_PDN_BEGIN)
        |=> cfg_r.powerdownWindowBegin == $past(pwdata[15:0]))
        else $error("Window start write not stored");
    pdn_finish_write_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (access && pwrite && mapped && idx == oart_pkg::IDX_PDN_FINISH)
        |=> cfg_r.powerdownWindowFinish == $past(pwdata[15:0]))
        else $error("Window end write not stored");
    pulse_write_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (access && pwrite && mapped && idx == oart_pkg::IDX_PULSE_BEGIN)
        |=> spareTimingPulseBegin == $past(pwdata[15:0]))
        else $error("Pulse start write not stored");
    led1_read_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (access && !pwrite && mapped && idx == oart_pkg::IDX_LED1) |=> prdata == {8'h00, $past(led1_r)})
        else $error("LED1 result read wrong");
    count_upper_zero_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (access && !pwrite && (idx == oart_pkg::IDX_PDN_BEGIN || idx == oart_pkg::IDX_PDN_FINISH))
        |=> prdata[31:16] == 16'h0000)
        else $error("Window count upper bits not zero");
    pulse_read_zero_a: assert property (@(posedge clk) disable iff (!rstSync_r)
        (access && !pwrite && idx == oart_pkg::IDX_PULSE_BEGIN) |=> prdata == 32'h0000_0000)
        else $error("Write-only pulse start read back");
endmodule

// file: testbench/oart_host_model.sv
// Host processor model: APB master for the result and timing register slice.
// Assumes a slave on clk that ends each access phase with pready.
`timescale 1ns/1ps
module oart_host_model (
    input  wire logic                        clk,
    input  wire logic [31:0]                 prdata,
    input  wire logic                        pready,
    input  wire logic                        pslverr,
    output logic                             psel,
    output logic                             penable,
    output logic                             pwrite,
    output logic [oart_pkg::ADDR_W-1:0]      paddr,
    output logic [31:0]                      pwdata
);
    // Divider field only ever gets codes 0,1,3,4,5,6
    // Third LED phase never used, so the 0x2E difference is trusted
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0000_0000;
    end

    // One transfer; byte address is four times the register index
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// file: testbench/oart_regs_bench.sv
// Self-checking bench for the result and timing register slice.
// Assumes the host model drives APB and the bench drives the core-side inputs.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
    $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module oart_regs_bench;
    typedef struct {logic [7:0] idx; logic [31:0] wd; logic [31:0] rd; logic er;} oart_row_t;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, dividedClock, ampPowerdown;
    logic        inputsToCommonMode, clockPinIsInput, e, prevDiv;
    logic [oart_pkg::ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        sampleValid = 1'b0;
    logic [23:0] s1 = '0, a1 = '0, s2 = '0, a2 = '0;
    logic [15:0] engineCount = '0, spare;
    logic        externalClockIn = 1'b0;
    logic [2:0]  extCnt = '0;
    int          err_count = 0, check_count = 0, cycles = 0, rises;
    oart_row_t   rows[10] = '{
        '{oart_pkg::IDX_CFG, 32'hFFFF_FF25, 32'h0000_0025, 1'b0},
        '{oart_pkg::IDX_PDN_BEGIN, 32'hFFFF_000A, 32'h0000_000A, 1'b0},
        '{oart_pkg::IDX_PDN_FINISH, 32'hABCD_0014, 32'h0000_0014, 1'b0},
        '{oart_pkg::IDX_PULSE_BEGIN, 32'h1234_5678, 32'h0000_0000, 1'b0},
        '{oart_pkg::IDX_LED1, 32'h0000_0055, 32'h0080_0001, 1'b0},
        '{oart_pkg::IDX_AMB1, 32'h0000_0001, 32'h0000_0003, 1'b0},
        '{oart_pkg::IDX_DIFF2, 32'h0000_0001, 32'h00FF_FFF0, 1'b0},
        '{oart_pkg::IDX_DIFF1, 32'h0000_0001, 32'h007F_FFFE, 1'b0},
        '{oart_pkg::IDX_CTRL, 32'h0000_0002, 32'h0000_0002, 1'b0},
        '{8'h3F, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
    logic [2:0]  codes[6] = '{3'h5, 3'h0, 3'h4, 3'h6, 3'h1, 3'h3};
    int          ratio[6] = '{1, 2, 4, 6, 8, 12};
    logic [15:0] cnts[5] = '{16'd9, 16'd10, 16'd19, 16'd20, 16'd15};

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        extCnt <= extCnt + 3'd1;
        externalClockIn <= extCnt[2];
        cycles++;
        if (cycles == 10000) begin
            err_count++;
            final_report();
        end
    end

    oart_host_model host_u (.clk(clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    oart_regs dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sampleValid(sampleValid), .firstLedSample(s1),
        .firstAmbientSample(a1), .secondLedSample(s2), .secondAmbientSample(a2),
        .engineCount(engineCount), .externalClockIn(externalClockIn),
        .dividedClock(dividedClock), .ampPowerdown(ampPowerdown),
        .inputsToCommonMode(inputsToCommonMode), .clockPinIsInput(clockPinIsInput),
        .spareTimingPulseBegin(spare));

    task automatic final_report();
        if (err_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic do_reset(input int n);
        rst_n <= 1'b0;
        repeat (n) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        do_reset(20);
        `CHK("pinInput", 1'b1, clockPinIsInput)
        for (int i = 0; i < 8; i++) begin
            host_u.xfer(1'b0, rows[i].idx, 32'h0, r, e);
            `CHK("resetValue", 32'h0000_0000, r)
        end
        s1 <= 24'h80_0001;
        a1 <= 24'h00_0003;
        s2 <= 24'h00_0010;
        a2 <= 24'h00_0020;
        sampleValid <= 1'b1;
        @(posedge clk);
        sampleValid <= 1'b0;
        foreach (rows[i]) begin
            host_u.xfer(1'b1, rows[i].idx, rows[i].wd, r, e);
            host_u.xfer(1'b0, rows[i].idx, 32'h0, r, e);
            `CHK("readBack", rows[i].rd, r)
            `CHK("slvErr", rows[i].er, e)
        end
        `CHK("pulseBegin", 16'h5678, spare)
        foreach (cnts[i]) begin
            if (i == 4) host_u.xfer(1'b1, oart_pkg::IDX_CFG, 32'h0000_0005, r, e);
            engineCount <= cnts[i];
            repeat (3) @(posedge clk);
            `CHK("ampDown", (i == 1 || i == 2 || i == 4), ampPowerdown)
            `CHK("shortIn", (i == 1 || i == 2), inputsToCommonMode)
        end
        foreach (codes[i]) begin
            host_u.xfer(1'b1, oart_pkg::IDX_CFG, {29'h0, codes[i]}, r, e);
            repeat (20) @(posedge clk);
            rises = 0;
            prevDiv = dividedClock;
            repeat (384) begin
                @(posedge clk);
                if (dividedClock === 1'b1 && prevDiv === 1'b0) rises++;
                prevDiv = dividedClock;
            end
            `CHK("divRatio", 1'b1, (rises >= 48 / ratio[i] - 1 && rises <= 48 / ratio[i] + 1))
        end
        host_u.xfer(1'b1, oart_pkg::IDX_CTRL, 32'h0000_0001, r, e);
        repeat (3) @(posedge clk);
        `CHK("pinInput", 1'b0, clockPinIsInput)
        `CHK("divIdle", 1'b0, dividedClock)
        do_reset(4);
        host_u.xfer(1'b0, oart_pkg::IDX_LED1, 32'h0, r, e);
        `CHK("ledAfterReset", 32'h0000_0000, r)
        host_u.xfer(1'b0, oart_pkg::IDX_CFG, 32'h0, r, e);
        `CHK("cfgAfterReset", 32'h0000_0000, r)
        `CHK("pinInput", 1'b1, clockPinIsInput)
        final_report();
    end
endmodule
